// [csp_partner.sv]
// link partner lane alignment model
`default_nettype none
module csp_partner (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bench control and device status
    input wire logic want,
    input wire logic [3:0] lag,
    input wire logic tx_align_status_out,
    // back to device
    output logic partner_rx_align_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg;
    // aligns lag+1 cycles after our tx lanes report aligned, drops one cycle after they drop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 4'h0;
            partner_rx_align_in <= 1'b0;
        end else if (!want || !tx_align_status_out) begin
            cnt_reg <= 4'h0;
            partner_rx_align_in <= 1'b0;
        end else if (cnt_reg != lag) begin
            cnt_reg <= cnt_reg + 4'h1;
        end else begin
            partner_rx_align_in <= 1'b1;
        end
    end
endmodule // csp_partner
`default_nettype wire

// [csp_pkg.sv]
// package of constants for the channel status and power-down block
`default_nettype none
package csp_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_LOSSRC = 4'h2;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_LOS_EN = 0;
    localparam int CTRL_REG_PD = 1;
    localparam int CTRL_REFSEL = 2;
    localparam int CTRL_TX_ALIGN = 3;
    localparam int CTRL_GPS_MODE = 4;
    localparam int CTRL_DP_RESET = 5;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    // ------------------------------------------------------------
    // loss flag source select
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_LOS = 2'h0;
    localparam logic [1:0] SRC_PARTNER = 2'h1;
    localparam logic [1:0] SRC_POWERED = 2'h2;
    localparam logic [1:0] SRC_TXALIGN = 2'h3;
    localparam logic [1:0] LOSSRC_RESET = 2'h0;
    localparam logic [3:0] LS_OUT_ZERO = 4'h0;
    // power-down synchroniser starts at the pin's idle (running) level
    localparam logic [1:0] SYNC_HIGH = 2'h3;
    typedef enum logic [1:0] {ST_RESET, ST_DOWN, ST_RUN} csp_state_t;
endpackage
`default_nettype wire

// [csp_top.sv]
// channel status, power-down and reference select logic
`default_nettype none
module csp_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // pins from outside
    input wire logic high_speed_serial_in,
    input wire logic partner_rx_align_in,
    input wire logic channel_powerdown_n,
    // pins to outside
    output logic signal_loss_flag,
    output logic signal_loss_flag_oe,
    output logic tx_align_status_out,
    output logic [3:0] low_speed_serial_out,
    output logic ls_out_enable,
    output logic ref_clock_sel_one,
    output logic channel_powered_down,
    output logic data_path_reset
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        csp_pkg::csp_state_t state;
        logic [1:0] pd_sync;
        logic [1:0] pa_sync;
        logic [1:0] hs_sync;
        logic [7:0] ctrl;
        logic [1:0] lossrc;
        logic [7:0] rdata;
        logic flag;
        logic flag_oe;
        logic txal;
        logic [3:0] ls;
        logic ls_en;
        logic refsel;
        logic pd;
        logic dpr;
        logic pd_seen;
    } csp_regs_t;

    csp_regs_t q_reg;
    csp_regs_t q_next;
    logic down;
    logic loss;
    logic src_bit;

    always_comb begin
        q_next = q_reg;
        // ------------------------------------------------------------
        // synchronisers
        // ------------------------------------------------------------
        // sync flops: the first stage feeds only the second
        q_next.pd_sync = {q_reg.pd_sync[0],
            channel_powerdown_n};
        q_next.pa_sync = {q_reg.pa_sync[0],
            partner_rx_align_in};
        q_next.hs_sync = {q_reg.hs_sync[0], high_speed_serial_in};
        down = !q_reg.pd_sync[1] || q_reg.ctrl[csp_pkg::CTRL_REG_PD];
        loss = !q_reg.hs_sync[1]; // activity level stands in for the detector
        // ------------------------------------------------------------
        // register port
        // ------------------------------------------------------------
        q_next.dpr = 1'b0;
        if (wr) begin
            case (addr)
                csp_pkg::ADDR_CTRL: begin
                    q_next.ctrl = wdata;
                    q_next.ctrl[csp_pkg::CTRL_DP_RESET] = 1'b0;
                    // data path reset is a one-cycle pulse
                    q_next.dpr = wdata[csp_pkg::CTRL_DP_RESET];
                    if (wdata[csp_pkg::CTRL_DP_RESET]) begin
                        q_next.pd_seen = 1'b0;
                    end
                end
                csp_pkg::ADDR_LOSSRC: q_next.lossrc = wdata[1:0];
                default: ;
            endcase
        end
        q_next.rdata = 8'h00;
        if (rd) begin
            case (addr)
                csp_pkg::ADDR_CTRL: q_next.rdata = q_reg.ctrl;
                csp_pkg::ADDR_STATUS: q_next.rdata = {3'h0, q_reg.pd_seen,
                    q_reg.pd, q_reg.pa_sync[1], q_reg.txal, loss};
                csp_pkg::ADDR_LOSSRC: q_next.rdata = {6'h00, q_reg.lossrc};
                default: q_next.rdata = 8'h00;
            endcase
        end
        // ------------------------------------------------------------
        // channel state
        // ------------------------------------------------------------
        case (q_reg.state)
            csp_pkg::ST_RESET: q_next.state = csp_pkg::ST_RUN;
            csp_pkg::ST_RUN: if (down) begin
                q_next.state = csp_pkg::ST_DOWN;
            end
            csp_pkg::ST_DOWN: if (!down) begin
                q_next.state = csp_pkg::ST_RUN;
                // software should follow with a data path reset
                q_next.pd_seen = 1'b1;
            end
            default: q_next.state = csp_pkg::ST_RESET;
        endcase
        q_next.pd = down;
        // ------------------------------------------------------------
        // outputs
        // ------------------------------------------------------------
        // gp-mode status only; outside that mode the pin reads zero
        q_next.txal = q_reg.ctrl[csp_pkg::CTRL_GPS_MODE]
            && q_reg.ctrl[csp_pkg::CTRL_TX_ALIGN];
        case (q_reg.lossrc)
            csp_pkg::SRC_LOS: src_bit = q_reg.ctrl[csp_pkg::CTRL_LOS_EN]
                && loss;
            csp_pkg::SRC_PARTNER: src_bit = q_reg.ctrl[csp_pkg::CTRL_GPS_MODE]
                && q_reg.pa_sync[1];
            csp_pkg::SRC_POWERED: src_bit = q_reg.pd;
            csp_pkg::SRC_TXALIGN: src_bit = q_reg.txal;
            default: src_bit = 1'b0;
        endcase
        q_next.flag = src_bit;
        q_next.flag_oe = !down;
        q_next.ls_en = !down;
        q_next.ls = q_reg.hs_sync[1] ? 4'hf : csp_pkg::LS_OUT_ZERO;
        q_next.refsel = q_reg.ctrl[csp_pkg::CTRL_REFSEL];
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_reg <= '0;
            q_reg.state <= csp_pkg::ST_RESET;
            // avoids a false power-down pulse right after reset
            q_reg.pd_sync <= csp_pkg::SYNC_HIGH;
            q_reg.ctrl <= csp_pkg::CTRL_RESET;
            q_reg.lossrc <= csp_pkg::LOSSRC_RESET;
            q_reg.flag <= 1'b0;
            q_reg.flag_oe <= 1'b1;
            q_reg.ls <= csp_pkg::LS_OUT_ZERO;
            q_reg.ls_en <= 1'b1;
        end else begin
            q_reg <= q_next;
        end
    end

    assign rdata = q_reg.rdata;
    assign signal_loss_flag = q_reg.flag;
    assign signal_loss_flag_oe = q_reg.flag_oe;
    assign tx_align_status_out = q_reg.txal;
    assign low_speed_serial_out = q_reg.ls;
    assign ls_out_enable = q_reg.ls_en;
    assign ref_clock_sel_one = q_reg.refsel;
    assign channel_powered_down = q_reg.pd;
    assign data_path_reset = q_reg.dpr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    los_flag_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (q_reg.lossrc == csp_pkg::SRC_LOS && $stable(q_reg.lossrc)
         && !q_reg.ctrl[csp_pkg::CTRL_LOS_EN]) |=> !signal_loss_flag)
        else $error("loss flag set while detection disabled");
    flag_float_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !q_reg.pd_sync[1] |=> !signal_loss_flag_oe)
        else $error("loss flag driven in power down");
    oe_run_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (q_reg.pd_sync[1] && !q_reg.ctrl[csp_pkg::CTRL_REG_PD])
        |=> signal_loss_flag_oe)
        else $error("loss flag not driven while running");
    pd_sync_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $fell(q_reg.pd_sync[1]) |=> channel_powered_down)
        else $error("power down not applied");
    reg_pd_a: assert property (
        @(posedge clk) disable iff (!nrst)
        q_reg.ctrl[csp_pkg::CTRL_REG_PD] |=> channel_powered_down)
        else $error("register power down not applied");
    pa_route_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (q_reg.lossrc == csp_pkg::SRC_PARTNER && $stable(q_reg.lossrc)
         && q_reg.ctrl[csp_pkg::CTRL_GPS_MODE])
        |=> signal_loss_flag == $past(q_reg.pa_sync[1]))
        else $error("partner alignment not shown");
    txal_gate_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !q_reg.ctrl[csp_pkg::CTRL_GPS_MODE] |=> !tx_align_status_out)
        else $error("align status outside gp mode");
    refsel_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 ref_clock_sel_one == $past(q_reg.ctrl[csp_pkg::CTRL_REFSEL]))
        else $error("reference select wrong");
    // back-to-back writes may legally give a longer pulse
    dpr_pulse_a: assert property (
        @(posedge clk) disable iff (!nrst)
        data_path_reset |-> $past(wr)
        && $past(wdata[csp_pkg::CTRL_DP_RESET])
        && $past(addr) == csp_pkg::ADDR_CTRL)
        else $error("data path reset without request");
    ls_float_a: assert property (
        @(posedge clk) disable iff (!nrst)
        channel_powered_down |-> !ls_out_enable || $past(!q_reg.pd))
        else $error("low speed outputs driven in power down");
    src_sel_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (q_reg.lossrc == csp_pkg::SRC_POWERED && $stable(q_reg.lossrc))
        |=> signal_loss_flag == $past(q_reg.pd))
        else $error("selected source not shown");
endmodule // csp_top
`default_nettype wire

// [testbench.sv]
// self-checking bench for the channel status block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, hs = 1'b1;
    logic pd_n = 1'b1, want = 1'b0, flag, oe, txa, ls_en, ref1, pdn, dpr, pal;
    logic [3:0] addr = 4'h0, lag = 4'h1, ls;
    logic [7:0] wdata = 8'h00, rdata, v;
    int err_count = 0;
    int num_checks = 0;
    always #50 clk = ~clk;
    csp_top i_csp_top (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .high_speed_serial_in(hs),
        .partner_rx_align_in(pal), .channel_powerdown_n(pd_n),
        .signal_loss_flag(flag), .signal_loss_flag_oe(oe),
        .tx_align_status_out(txa), .low_speed_serial_out(ls),
        .ls_out_enable(ls_en), .ref_clock_sel_one(ref1),
        .channel_powered_down(pdn), .data_path_reset(dpr));
    csp_partner i_csp_partner (.clk(clk), .nrst(nrst), .want(want), .lag(lag),
        .tx_align_status_out(txa), .partner_rx_align_in(pal));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    // checks land at falling edges, well clear of the launching edge
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic exp_flag(logic [1:0] s, logic h, logic p);
        case (s)
            csp_pkg::SRC_LOS: return !h;
            csp_pkg::SRC_PARTNER: return p;
            csp_pkg::SRC_TXALIGN: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        v = 8'($urandom(57));
        cyc(6);
        chk("rst_flag", {oe, flag}, 8'h02);
        chk("rst_ls", {ls_en, ls}, 8'h10);
        @(posedge clk) nrst <= 1'b1;
        rdr(csp_pkg::ADDR_CTRL);
        chk("ctrl", v, csp_pkg::CTRL_RESET);
        rdr(4'h9);
        chk("unmapped", v, 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) hs <= 1'($urandom);
            cyc(4);
            chk("loss", 8'(flag), 8'(!hs));
            chk("ls", {4'h0, ls}, hs ? 8'h0f : 8'h00);
        end
        wrr(csp_pkg::ADDR_CTRL, 8'h19);
        @(posedge clk) lag <= 4'($urandom_range(1, 9));
        want <= 1'b1;
        cyc(16);
        chk("txa", 8'(txa), 8'h01);
        rdr(csp_pkg::ADDR_STATUS);
        chk("stat_pa", 8'(v[2]), 8'h01);
        for (int s = 0; s < 4; s++) begin
            wrr(csp_pkg::ADDR_LOSSRC, 8'(s));
            cyc(4);
            chk("src", 8'(flag), 8'(exp_flag(2'(s), hs, pal)));
        end
        wrr(csp_pkg::ADDR_CTRL, 8'h15);
        cyc(4);
        chk("ref_txa", {ref1, txa}, 8'h02);
        @(posedge clk) pd_n <= 1'b0;
        cyc(4);
        chk("pd_pin", {pdn, oe, ls_en}, 8'h04);
        @(posedge clk) pd_n <= 1'b1;
        cyc(4);
        chk("pd_off", {pdn, oe, ls_en}, 8'h03);
        rdr(csp_pkg::ADDR_STATUS);
        chk("pd_seen", 8'(v[4]), 8'h01);
        wrr(csp_pkg::ADDR_CTRL, 8'h13);
        cyc(2);
        chk("pd_reg", {pdn, oe, ls_en}, 8'h04);
        wrr(csp_pkg::ADDR_CTRL, 8'h11);
        @(posedge clk);
        wdata <= 8'h31;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
        v = 8'h00;
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            v = v + 8'(dpr);
        end
        chk("dp_pulse", v, 8'h01);
        rdr(csp_pkg::ADDR_STATUS);
        chk("pd_clr", 8'(v[4]), 8'h00);
        wrr(csp_pkg::ADDR_LOSSRC, 8'h00);
        @(posedge clk) hs <= 1'b0;
        wrr(csp_pkg::ADDR_CTRL, 8'h10);
        cyc(4);
        chk("los_off", 8'(flag), 8'h00);
        wrr(csp_pkg::ADDR_CTRL, 8'h11);
        cyc(4);
        chk("los_on", 8'(flag), 8'h01);
        final_report;
    end
endmodule // testbench
`default_nettype wire
